// *** inc/isf_pkg.sv ***
// Purpose: constants and types for the interrupt source flag block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: register offsets other than watchdog_control are local choices
package isf_pkg;
	// register byte addresses
	localparam logic [11:0] ISF_ADDR_WATCHDOG_CONTROL = 12'h0D8; // watchdog_control
	localparam logic [11:0] ISF_ADDR_ENABLE = 12'h100; // per-source enables
	localparam logic [11:0] ISF_ADDR_CTRL = 12'h104; // global and mode bits
	localparam logic [11:0] ISF_ADDR_FLAGS = 12'h108; // flag status, write 1 to clear, except spi done which clears on a written 0
	localparam logic [11:0] ISF_ADDR_REQ = 12'h10C; // registered requests
	localparam logic [11:0] ISF_ADDR_TA = 12'h110; // timed-access key
	localparam logic [11:0] ISF_ADDR_KEYEN = 12'h114; // keypad line enables
	localparam logic [11:0] ISF_ADDR_RSTCAUSE = 12'h118; // reset cause strobes
	// source indices (17 sources)
	localparam int ISF_NSRC = 17;
	localparam int ISF_S_EXT0 = 0;
	localparam int ISF_S_BROWN = 1;
	localparam int ISF_S_WDT = 2;
	localparam int ISF_S_TMR0 = 3;
	localparam int ISF_S_SPI = 4;
	localparam int ISF_S_I2C = 5;
	localparam int ISF_S_ADC = 6;
	localparam int ISF_S_EXT1 = 7;
	localparam int ISF_S_TMR1 = 8;
	localparam int ISF_S_SER = 9;
	localparam int ISF_S_TMR2 = 10;
	localparam int ISF_S_TMR3 = 11;
	localparam int ISF_S_CAPT = 12;
	localparam int ISF_S_KEY = 13;
	localparam int ISF_S_CMP = 14;
	localparam int ISF_S_PWM = 15;
	localparam int ISF_S_BRAKE = 16;
	// ctrl register fields
	localparam int ISF_C_GLOBAL = 0;
	localparam int ISF_C_IT0 = 1;
	localparam int ISF_C_IT1 = 2;
	localparam int ISF_C_BOSEL = 3;
	localparam int ISF_C_BK0EN = 4;
	localparam int ISF_C_BK1EN = 5;
	// flag register bit positions
	localparam int ISF_NFLAG = 24;
	localparam int ISF_F_EXT0 = 0;
	localparam int ISF_F_EXT1 = 1;
	localparam int ISF_F_TF0 = 2;
	localparam int ISF_F_TF1 = 3;
	localparam int ISF_F_TF2 = 4;
	localparam int ISF_F_TF3 = 5;
	localparam int ISF_F_CAP0 = 6;
	localparam int ISF_F_RX = 9;
	localparam int ISF_F_TX = 10;
	localparam int ISF_F_SPIDONE = 11;
	localparam int ISF_F_SPI_MODE_FAULT_FLAG = 12;
	localparam int ISF_F_SPIOVR = 13;
	localparam int ISF_F_KEY = 14;
	localparam int ISF_F_CMP1 = 15;
	localparam int ISF_F_CMP2 = 16;
	localparam int ISF_F_PWM = 17;
	localparam int ISF_F_BRK0 = 18;
	localparam int ISF_F_BRK1 = 19;
	localparam int ISF_F_ADCDONE = 20;
	localparam int ISF_F_ADCCMP = 21;
	localparam int ISF_F_BROWN = 22;
	localparam int ISF_F_I2C = 23;
	// watchdog_control fields
	localparam int ISF_W_RESTART = 0;
	localparam int ISF_W_RSTEN = 1;
	localparam int ISF_W_CAUSE = 2;
	localparam int ISF_W_IRQF = 3;
	localparam int ISF_W_IVLO = 4;
	localparam int ISF_W_IVHI = 5;
	localparam int ISF_W_RUN = 7;
	localparam logic [7:0] ISF_WD_TIMED = 8'hBB; // bits needing timed access
	localparam logic [7:0] ISF_WD_RESET = 8'h00;
	// timed-access keys and window
	localparam logic [7:0] ISF_TA_KEY1 = 8'hAA;
	localparam logic [7:0] ISF_TA_KEY2 = 8'h55;
	localparam logic [2:0] ISF_TA_WINDOW = 3'h4; // machine cycles of open window
	// last clock phase of the four-clock machine cycle
	localparam logic [1:0] ISF_MC_LAST = 2'h3;
	localparam logic [ISF_NFLAG-1:0] ISF_FLAGS_RESET = 24'h000000;
	localparam logic [ISF_NSRC-1:0] ISF_EN_RESET = 17'h00000;
	// peripheral event strobes, one clock each
	typedef struct packed {
		logic tmr0_ovf;
		logic tmr1_ovf;
		logic tmr2_evt;
		logic tmr3_evt;
		logic [2:0] capt;
		logic rx_done;
		logic tx_done;
		logic spi_done;
		logic spi_spi_mode_fault_flag;
		logic spi_ovr;
		logic cmp1_chg;
		logic cmp2_chg;
		logic pwm_period;
		logic adc_done;
		logic adc_cmp;
		logic wdt_timeout;
		logic i2c_state;
	} isf_evt_t;
	// service-entry strobes from the cpu vectoring logic
	typedef struct packed {
		logic ext0;
		logic ext1;
		logic tmr0;
		logic tmr1;
	} isf_ack_t;
endpackage : isf_pkg

// *** design/isf_top.sv ***
// Purpose: request flags of all interrupt sources, apb register access
// Assumes: pins async to I_MCLK, events are one-clock strobes on I_MCLK
// Notes: a machine cycle is four clocks; requests update on its boundary
//
// What this block does
// - seventeen sources, flags, enables, global enable
// - ext inputs select edge or level
// - edge mode sets flag on high-then-low sample
// - edge flag cleared on service entry
// - level flag follows pin, re-requests
// - timer0/1 overflow flags cleared on service
// - watchdog timeout flag, request needs enable
// - timer2/3 flags set by events, software clears
// - capture request ORs three capture flags
// - serial rx/tx done flags, software clears
// - i2c requests on new state code
// - spi done, fault, overrun share vector
// - enabled keypad press sets keyboard flag
// - comparator change sets its flag
// - pwm period flag set on counter event
// - brake falling edge sets flag when enabled
// - two adc flags on conversion done
// - brownout requests need select, enable, global
// - watchdog cause flag depends on reset kind
// - any reset clears reset-enable and irq flag
// - protected watchdog bits need timed access
// - requests recomputed every cycle, not remembered
`timescale 1ns/1ps
`default_nettype none
module isf_top
	import isf_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic [11:0] I_PADDR,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_EXT0_PIN,
	input wire logic I_EXT1_PIN,
	input wire logic [7:0] I_KEYPAD_PIN,
	input wire logic I_BRAKE0_PIN,
	input wire logic I_BRAKE1_PIN,
	input wire logic I_BROWNOUT,
	input wire isf_evt_t I_EVT,
	input wire isf_ack_t I_ACK,
	input wire logic I_WDT_RESET,
	input wire logic I_POR_RESET,
	output logic [ISF_NSRC-1:0] O_REQ,
	output logic [7:0] O_WATCHDOG_CONTROL
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [11:0] sync1_r, sync2_r;
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			// brownout idles low, every other pin idles high
			sync1_r <= 12'h7FF;
			sync2_r <= 12'h7FF;
		end else begin
			sync1_r <= {I_BROWNOUT, I_BRAKE1_PIN, I_BRAKE0_PIN, I_KEYPAD_PIN, I_EXT1_PIN};
			sync2_r <= sync1_r;
		end
	end

	logic ext0_s, ext1_s, brk0_s, brk1_s, brown_s;
	logic [7:0] key_s;

	logic ext0_sync1_r, ext0_sync2_r;
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ext0_sync1_r <= 1'b1;
			ext0_sync2_r <= 1'b1;
		end else begin
			ext0_sync1_r <= I_EXT0_PIN;
			ext0_sync2_r <= ext0_sync1_r;
		end
	end

	assign ext0_s = ext0_sync2_r;
	assign ext1_s = sync2_r[0];
	assign key_s = sync2_r[8:1];
	assign brk0_s = sync2_r[9];
	assign brk1_s = sync2_r[10];
	// a level: the flag keeps setting for as long as the supply stays low
	assign brown_s = sync2_r[11];

	// ----------------------------------------------------------------
	// machine cycle phase and per-cycle samples
	// ----------------------------------------------------------------
	logic [1:0] phase_r, phase_nxt;
	logic mc_end;
	logic [3:0] samp_r, samp_nxt; // ext0, ext1, brk0, brk1 previous samples
	logic [7:0] key_samp_r, key_samp_nxt;
	assign mc_end = (phase_r == ISF_MC_LAST);
	always_comb begin
		phase_nxt = phase_r + 2'h1;
		samp_nxt = samp_r;
		key_samp_nxt = key_samp_r;
		if (mc_end) begin
			samp_nxt = {ext0_s, ext1_s, brk0_s, brk1_s};
			key_samp_nxt = key_s;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			phase_r <= 2'h0;
			samp_r <= 4'hF;
			key_samp_r <= 8'hFF;
		end else begin
			phase_r <= phase_nxt;
			samp_r <= samp_nxt;
			key_samp_r <= key_samp_nxt;
		end
	end

	// high-then-low between consecutive machine-cycle samples
	logic fall0, fall1, bfall0, bfall1, key_press;
	logic [7:0] key_en_r, key_en_nxt;
	assign fall0 = mc_end & samp_r[3] & ~ext0_s;
	assign fall1 = mc_end & samp_r[2] & ~ext1_s;
	assign bfall0 = mc_end & samp_r[1] & ~brk0_s;
	assign bfall1 = mc_end & samp_r[0] & ~brk1_s;
	assign key_press = mc_end & |(key_samp_r & ~key_s & key_en_r);

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic wr_acc, rd_acc;
	assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
		hit = (a == base);
	endfunction : hit

	logic addr_ok;
	assign addr_ok = hit(I_PADDR, ISF_ADDR_WATCHDOG_CONTROL) | hit(I_PADDR, ISF_ADDR_ENABLE)
		| hit(I_PADDR, ISF_ADDR_CTRL) | hit(I_PADDR, ISF_ADDR_FLAGS)
		| hit(I_PADDR, ISF_ADDR_REQ) | hit(I_PADDR, ISF_ADDR_TA)
		| hit(I_PADDR, ISF_ADDR_KEYEN) | hit(I_PADDR, ISF_ADDR_RSTCAUSE);

	assign O_PREADY = 1'b1; // zero wait states
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;

	// ----------------------------------------------------------------
	// control registers and timed access
	// ----------------------------------------------------------------
	logic [ISF_NSRC-1:0] en_r, en_nxt;
	logic [5:0] ctrl_r, ctrl_nxt;
	logic [1:0] ta_st_r, ta_st_nxt; // 0 idle, 1 first key seen, 2 open
	logic [2:0] ta_cnt_r, ta_cnt_nxt;
	logic ta_open;
	assign ta_open = (ta_st_r == 2'h2);

	always_comb begin
		en_nxt = en_r;
		ctrl_nxt = ctrl_r;
		key_en_nxt = key_en_r;
		ta_st_nxt = ta_st_r;
		ta_cnt_nxt = ta_cnt_r;
		// a started or open key sequence lapses when the window runs out
		if (ta_st_r != 2'h0 && mc_end) begin
			ta_cnt_nxt = ta_cnt_r - 3'h1;
			if (ta_cnt_r == 3'h0) ta_st_nxt = 2'h0;
		end
		if (wr_acc) begin
			if (hit(I_PADDR, ISF_ADDR_ENABLE)) begin
				en_nxt = I_PWDATA[ISF_NSRC-1:0];
			end else if (hit(I_PADDR, ISF_ADDR_CTRL)) begin
				ctrl_nxt = I_PWDATA[5:0];
			end else if (hit(I_PADDR, ISF_ADDR_KEYEN)) begin
				key_en_nxt = I_PWDATA[7:0];
			end else if (hit(I_PADDR, ISF_ADDR_TA)) begin
				ta_cnt_nxt = ISF_TA_WINDOW;
				if (I_PWDATA[7:0] == ISF_TA_KEY1) ta_st_nxt = 2'h1;
				else if (I_PWDATA[7:0] == ISF_TA_KEY2 && ta_st_r == 2'h1) ta_st_nxt = 2'h2;
				else ta_st_nxt = 2'h0;
			end else if (hit(I_PADDR, ISF_ADDR_WATCHDOG_CONTROL)) begin
				ta_st_nxt = 2'h0; // one protected write per key sequence
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			en_r <= ISF_EN_RESET;
			ctrl_r <= 6'h00;
			key_en_r <= 8'h00;
			ta_st_r <= 2'h0;
			ta_cnt_r <= 3'h0;
		end else begin
			en_r <= en_nxt;
			ctrl_r <= ctrl_nxt;
			key_en_r <= key_en_nxt;
			ta_st_r <= ta_st_nxt;
			ta_cnt_r <= ta_cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// watchdog control register
	// ----------------------------------------------------------------
	// the cause bit survives the async reset, so it has its own reset-free
	// path: por strobe clears it, watchdog reset strobe sets it
	logic [7:0] wd_r, wd_nxt;
	logic cause_r, cause_nxt;
	logic wd_wr;
	assign wd_wr = wr_acc & hit(I_PADDR, ISF_ADDR_WATCHDOG_CONTROL);

	always_comb begin
		wd_nxt = wd_r;
		if (wd_wr) begin
			// protected bits only change inside the timed window
			wd_nxt = ta_open ? I_PWDATA[7:0] : ((wd_r & ISF_WD_TIMED) | (I_PWDATA[7:0] & ~ISF_WD_TIMED));
		end
		wd_nxt[ISF_W_CAUSE] = 1'b0;
		wd_nxt[6] = 1'b0;
		if (I_EVT.wdt_timeout) wd_nxt[ISF_W_IRQF] = 1'b1;
	end

	always_comb begin
		cause_nxt = cause_r;
		// cause is not a protected bit, so a plain write reaches it
		if (wd_wr) cause_nxt = I_PWDATA[ISF_W_CAUSE];
		if (I_WDT_RESET) cause_nxt = 1'b1;
		if (I_POR_RESET) cause_nxt = 1'b0;
	end
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			wd_r <= ISF_WD_RESET;
		end else begin
			wd_r <= wd_nxt;
		end
	end

	always_ff @(posedge I_MCLK) begin
		cause_r <= cause_nxt;
	end

	assign O_WATCHDOG_CONTROL = {wd_r[7:3], cause_r, wd_r[1:0]};

	// ----------------------------------------------------------------
	// request flags
	// ----------------------------------------------------------------
	// hardware sets beat software clears in the same cycle
	logic [ISF_NFLAG-1:0] flg_r, flg_nxt, set_v, hw_clr, sw_clr;
	logic fl_wr;
	assign fl_wr = wr_acc & hit(I_PADDR, ISF_ADDR_FLAGS);

	always_comb begin
		set_v = '0;
		hw_clr = '0;
		set_v[ISF_F_EXT0] = ctrl_r[ISF_C_IT0] ? fall0 : (mc_end & ~ext0_s);
		set_v[ISF_F_EXT1] = ctrl_r[ISF_C_IT1] ? fall1 : (mc_end & ~ext1_s);
		// level mode: flag is cleared each sample when pin went high again
		hw_clr[ISF_F_EXT0] = ctrl_r[ISF_C_IT0] ? I_ACK.ext0 : (mc_end & ext0_s);
		hw_clr[ISF_F_EXT1] = ctrl_r[ISF_C_IT1] ? I_ACK.ext1 : (mc_end & ext1_s);
		set_v[ISF_F_TF0] = I_EVT.tmr0_ovf;
		set_v[ISF_F_TF1] = I_EVT.tmr1_ovf;
		hw_clr[ISF_F_TF0] = I_ACK.tmr0;
		hw_clr[ISF_F_TF1] = I_ACK.tmr1;
		set_v[ISF_F_TF2] = I_EVT.tmr2_evt;
		set_v[ISF_F_TF3] = I_EVT.tmr3_evt;
		set_v[ISF_F_CAP0 +: 3] = I_EVT.capt;
		set_v[ISF_F_RX] = I_EVT.rx_done;
		set_v[ISF_F_TX] = I_EVT.tx_done;
		set_v[ISF_F_SPIDONE] = I_EVT.spi_done;
		set_v[ISF_F_SPI_MODE_FAULT_FLAG] = I_EVT.spi_spi_mode_fault_flag;
		set_v[ISF_F_SPIOVR] = I_EVT.spi_ovr;
		set_v[ISF_F_KEY] = key_press;
		set_v[ISF_F_CMP1] = I_EVT.cmp1_chg;
		set_v[ISF_F_CMP2] = I_EVT.cmp2_chg;
		set_v[ISF_F_PWM] = I_EVT.pwm_period;
		set_v[ISF_F_BRK0] = bfall0 & ctrl_r[ISF_C_BK0EN];
		set_v[ISF_F_BRK1] = bfall1 & ctrl_r[ISF_C_BK1EN];
		set_v[ISF_F_ADCDONE] = I_EVT.adc_done;
		set_v[ISF_F_ADCCMP] = I_EVT.adc_cmp;
		set_v[ISF_F_BROWN] = brown_s;
		set_v[ISF_F_I2C] = I_EVT.i2c_state;
	end

	// software clears: write 1 to clear, except spi done which clears on a written 0
	always_comb begin
		sw_clr = fl_wr ? I_PWDATA[ISF_NFLAG-1:0] : '0;
		sw_clr[ISF_F_SPIDONE] = fl_wr & ~I_PWDATA[ISF_F_SPIDONE];
		flg_nxt = (flg_r & ~(sw_clr | hw_clr)) | set_v;
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			flg_r <= ISF_FLAGS_RESET;
		end else begin
			flg_r <= flg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// per-source request, registered at machine cycle end
	// ----------------------------------------------------------------
	logic [ISF_NSRC-1:0] src_flag, req_r, req_nxt;
	always_comb begin
		src_flag = '0;
		src_flag[ISF_S_EXT0] = flg_r[ISF_F_EXT0];
		src_flag[ISF_S_EXT1] = flg_r[ISF_F_EXT1];
		src_flag[ISF_S_TMR0] = flg_r[ISF_F_TF0];
		src_flag[ISF_S_TMR1] = flg_r[ISF_F_TF1];
		src_flag[ISF_S_TMR2] = flg_r[ISF_F_TF2];
		src_flag[ISF_S_TMR3] = flg_r[ISF_F_TF3];
		src_flag[ISF_S_CAPT] = |flg_r[ISF_F_CAP0 +: 3];
		src_flag[ISF_S_SER] = flg_r[ISF_F_RX] | flg_r[ISF_F_TX];
		src_flag[ISF_S_SPI] = |flg_r[ISF_F_SPIDONE +: 3];
		src_flag[ISF_S_KEY] = flg_r[ISF_F_KEY];
		src_flag[ISF_S_CMP] = flg_r[ISF_F_CMP1] | flg_r[ISF_F_CMP2];
		src_flag[ISF_S_PWM] = flg_r[ISF_F_PWM];
		src_flag[ISF_S_BRAKE] = flg_r[ISF_F_BRK0] | flg_r[ISF_F_BRK1];
		src_flag[ISF_S_ADC] = flg_r[ISF_F_ADCDONE] | flg_r[ISF_F_ADCCMP];
		src_flag[ISF_S_BROWN] = flg_r[ISF_F_BROWN] & ctrl_r[ISF_C_BOSEL];
		src_flag[ISF_S_WDT] = wd_r[ISF_W_IRQF];
		src_flag[ISF_S_I2C] = flg_r[ISF_F_I2C];
	end

	// no memory of refused requests: recomputed from flags each cycle
	always_comb begin
		req_nxt = req_r;
		if (mc_end) req_nxt = src_flag & en_r & {ISF_NSRC{ctrl_r[ISF_C_GLOBAL]}};
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	assign O_REQ = req_r;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] rdata_r, rdata_nxt;
	always_comb begin
		rdata_nxt = rdata_r;
		if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
			if (hit(I_PADDR, ISF_ADDR_WATCHDOG_CONTROL)) rdata_nxt = {24'h000000, O_WATCHDOG_CONTROL};
			else if (hit(I_PADDR, ISF_ADDR_ENABLE)) rdata_nxt = {15'h0000, en_r};
			else if (hit(I_PADDR, ISF_ADDR_CTRL)) rdata_nxt = {26'h0000000, ctrl_r};
			else if (hit(I_PADDR, ISF_ADDR_FLAGS)) rdata_nxt = {8'h00, flg_r};
			else if (hit(I_PADDR, ISF_ADDR_REQ)) rdata_nxt = {15'h0000, req_r};
			else if (hit(I_PADDR, ISF_ADDR_TA)) rdata_nxt = {30'h00000000, ta_st_r};
			else if (hit(I_PADDR, ISF_ADDR_KEYEN)) rdata_nxt = {24'h000000, key_en_r};
			else rdata_nxt = 32'h00000000;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// zero outside the access phase, so an idle bus shows no stale data
	assign O_PRDATA = rd_acc ? rdata_r : 32'h00000000;
endmodule : isf_top
`default_nettype wire

// *** verif/isf_top_sva.sv ***
// Purpose: port-level checker for the interrupt source flag block
// Assumes: machine cycle of four clocks counted from reset release
// Notes: enable, control and key writes are shadowed from the apb port
`timescale 1ns/1ps
`default_nettype none
module isf_sva_chk
	import isf_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic [11:0] I_PADDR,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [31:0] I_PWDATA,
	input wire isf_evt_t I_EVT,
	input wire isf_ack_t I_ACK,
	input wire logic I_POR_RESET,
	input wire logic [ISF_NSRC-1:0] O_REQ,
	input wire logic [7:0] O_WATCHDOG_CONTROL
);
	logic [1:0] ph_r, ph_nxt;
	logic [ISF_NSRC-1:0] en_r, en_nxt;
	logic [31:0] ctl_r, ctl_nxt;
	logic [4:0] ta_r, ta_nxt;
	logic wr;
	// ----------------------------------------
	// shadows of phase, enables and key window
	// ----------------------------------------
	// the key window is a loose upper bound, so a late write is not flagged
	assign wr = I_PSEL && I_PENABLE && I_PWRITE;
	always_comb begin
		ph_nxt = ph_r + 2'h1;
		en_nxt = (wr && I_PADDR == ISF_ADDR_ENABLE) ? I_PWDATA[ISF_NSRC-1:0] : en_r;
		ctl_nxt = (wr && I_PADDR == ISF_ADDR_CTRL) ? I_PWDATA : ctl_r;
		ta_nxt = (ta_r != 5'h00) ? ta_r - 5'h01 : 5'h00;
		if (wr && I_PADDR == ISF_ADDR_TA && I_PWDATA[7:0] == ISF_TA_KEY2) ta_nxt = 5'h14;
	end
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ph_r <= 2'h0;
			en_r <= '0;
			ctl_r <= 32'h0;
			ta_r <= 5'h00;
		end else begin
			ph_r <= ph_nxt;
			en_r <= en_nxt;
			ctl_r <= ctl_nxt;
			ta_r <= ta_nxt;
		end
	end
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	// requests move only on the machine cycle boundary
	a_req_mc_edge: assert property ($changed(O_REQ) |-> ph_r == 2'h0)
		else $error("request moved off the machine cycle boundary");
	a_req_en_gate: assert property (ph_r == 2'h0 |-> (O_REQ & ~$past(en_r)) == '0)
		else $error("request raised for a disabled source");
	a_req_global_off: assert property ((ph_r == 2'h0 && !$past(ctl_r[ISF_C_GLOBAL])) |-> O_REQ == '0)
		else $error("request raised with global enable off");
	a_evt_to_req: assert property ((I_EVT.tmr2_evt && en_r[ISF_S_TMR2] && ctl_r[ISF_C_GLOBAL])
		|-> ##[1:5] O_REQ[ISF_S_TMR2])
		else $error("timer2 event gave no request");
	a_tmr0_ack_clr: assert property ((I_ACK.tmr0 && !I_EVT.tmr0_ovf) ##1 (!I_EVT.tmr0_ovf) [*5]
		|-> !O_REQ[ISF_S_TMR0])
		else $error("timer0 request stood after service");
	a_watchdog_control_rst: assert property ($rose(I_RSTN) |-> (O_WATCHDOG_CONTROL & 8'hFB) == 8'h00)
		else $error("watchdog control not cleared by reset");
	a_por_cause: assert property (I_POR_RESET |=> !O_WATCHDOG_CONTROL[ISF_W_CAUSE])
		else $error("power-on reset left the cause flag set");
	a_wd_timed: assert property (($changed(O_WATCHDOG_CONTROL[ISF_W_RUN]) || $changed(O_WATCHDOG_CONTROL[ISF_W_RSTEN])
		|| $changed(O_WATCHDOG_CONTROL[5:4])) |-> $past(ta_r) != 5'h00)
		else $error("protected watchdog bit changed without the key");
	c_ext_service: cover property (I_ACK.ext0);
	c_wdt_req: cover property (O_REQ[ISF_S_WDT]);
	c_brake_req: cover property (O_REQ[ISF_S_BRAKE]);
endmodule : isf_sva_chk
bind isf_top isf_sva_chk u_isf_sva_chk (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_PADDR(I_PADDR),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA),
	.I_EVT(I_EVT), .I_ACK(I_ACK), .I_POR_RESET(I_POR_RESET), .O_REQ(O_REQ), .O_WATCHDOG_CONTROL(O_WATCHDOG_CONTROL));
`default_nettype wire

// *** verif/isf_cpu_model.sv ***
// Purpose: cpu vectoring stand-in that enters service routines on request
// Assumes: requests are levels, service-entry strobes last one clock
// Notes: one source per entry; slow mode delays entry by three clocks
`timescale 1ns/1ps
`default_nettype none
module isf_cpu_model
	import isf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [ISF_NSRC-1:0] i_req,
	input wire logic i_ack_en,
	input wire logic i_slow,
	output var isf_ack_t o_ack
);
	logic [3:0] cnt_r, cnt_nxt;
	isf_ack_t ack_nxt;
	logic e0, t0, e1;
	// ----------------------------------------
	// service entry
	// ----------------------------------------
	// only a request still high at entry is served, nothing is queued
	assign e0 = i_req[ISF_S_EXT0];
	assign t0 = i_req[ISF_S_TMR0];
	assign e1 = i_req[ISF_S_EXT1];
	always_comb begin
		ack_nxt = '0;
		cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
		if (cnt_r == 4'h0 && i_ack_en && (e0 | t0 | e1 | i_req[ISF_S_TMR1])) cnt_nxt = i_slow ? 4'hC : 4'h9;
		if (cnt_r == 4'h8 && i_ack_en) begin
			ack_nxt.ext0 = e0;
			ack_nxt.tmr0 = t0 & ~e0;
			ack_nxt.ext1 = e1 & ~e0 & ~t0;
			ack_nxt.tmr1 = i_req[ISF_S_TMR1] & ~e0 & ~t0 & ~e1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r <= 4'h0;
			o_ack <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			o_ack <= ack_nxt;
		end
	end
endmodule : isf_cpu_model
`default_nettype wire

// *** verif/test_interrupt_source_flags.sv ***
// Purpose: self-checking bench for the interrupt source flag block
// Assumes: apb slave answers without wait states
// Notes: a behavioural flag model predicts every flag and request read
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_source_flags import isf_pkg::*;;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
	logic pready, perr, wdr = 1'b0, por = 1'b0, bo = 1'b0, ack_en = 1'b0, slow = 1'b0;
	logic [11:0] pa = 12'h000, pins = 12'hFFF;
	logic [31:0] pwd = 32'h0, prd, rd, mf = 32'h0, mc = 32'h0;
	logic [ISF_NSRC-1:0] req, me = '0;
	logic [7:0] watchdog_control, mw = 8'h00;
	logic ta = 1'b0, ka = 1'b0;
	isf_evt_t evt = '0;
	isf_ack_t ack;
	int err_total = 0, tests_run = 0, seed = 32'hB410, k;
	int eb[18] = '{18, 17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 0};
	int fb[18] = '{2, 3, 4, 5, 8, 7, 6, 9, 10, 11, 12, 13, 15, 16, 17, 20, 21, 23};
	int pp[7] = '{0, 1, 2, 2, 3, 4, 5};
	int pc[7] = '{3, 5, 1, 17, 33, 1, 1};
	int pf[7] = '{0, 1, -1, 18, 19, 14, -1};
	isf_top u_isf_top (.I_MCLK(clk), .I_RSTN(rstn), .I_PADDR(pa), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(perr),
		.I_EXT0_PIN(pins[0]), .I_EXT1_PIN(pins[1]), .I_KEYPAD_PIN(pins[11:4]),
		.I_BRAKE0_PIN(pins[2]), .I_BRAKE1_PIN(pins[3]), .I_BROWNOUT(bo), .I_EVT(evt),
		.I_ACK(ack), .I_WDT_RESET(wdr), .I_POR_RESET(por), .O_REQ(req), .O_WATCHDOG_CONTROL(watchdog_control));
	isf_cpu_model u_isf_cpu_model (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_ack_en(ack_en),
		.i_slow(slow), .o_ack(ack));
	// ----------------------------------------
	// clock, model and bus tasks
	// ----------------------------------------
	initial forever #5 clk = ~clk;
	// service entry clears timer flags, and external flags only in edge mode
	always @(posedge clk) if (rstn) begin
		if (ack.tmr0) mf[2] = 1'b0;
		if (ack.tmr1) mf[3] = 1'b0;
		if (ack.ext0 && mc[ISF_C_IT0]) mf[0] = 1'b0;
		if (ack.ext1 && mc[ISF_C_IT1]) mf[1] = 1'b0;
	end
	function automatic logic [ISF_NSRC-1:0] mreq();
		logic [ISF_NSRC-1:0] s;
		s = {|mf[19:18], mf[17], |mf[16:15], mf[14], |mf[8:6], mf[5], mf[4], |mf[10:9], mf[3],
			mf[1], |mf[21:20], mf[23], |mf[13:11], mf[2], mw[3], mf[22] & mc[ISF_C_BOSEL], mf[0]};
		return s & me & {ISF_NSRC{mc[ISF_C_GLOBAL]}};
	endfunction : mreq
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// the model follows a write only once the access edge has passed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pa <= a;
		pwr <= w;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (w) case (a)
			ISF_ADDR_ENABLE: me = d[ISF_NSRC-1:0];
			ISF_ADDR_CTRL: mc = d;
			ISF_ADDR_FLAGS: mf = mf & ~(d & 32'hFFFFF7FF) & ~(d[11] ? 32'h0 : 32'h800);
			ISF_ADDR_TA: ta = ka && d[7:0] == ISF_TA_KEY2;
			ISF_ADDR_WATCHDOG_CONTROL: begin
				if (ta) mw = (mw & 8'h04) | (d[7:0] & ISF_WD_TIMED);
				mw[ISF_W_CAUSE] = d[ISF_W_CAUSE];
				ta = 1'b0;
			end
			default: ;
		endcase
		ka = w && a == ISF_ADDR_TA && d[7:0] == ISF_TA_KEY1;
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	task automatic pulse(input int b);
		@(posedge clk);
		evt <= isf_evt_t'(19'h1 << b);
		@(posedge clk);
		evt <= '0;
	endtask : pulse
	task automatic do_reset();
		rstn <= 1'b0;
		cyc(4);
		rstn <= 1'b1;
		me = '0;
		mc = 32'h0;
		mf = 32'h0;
		mw = mw & 8'h04;
	endtask : do_reset
	task automatic strobe_cause(input logic wd);
		@(posedge clk);
		if (wd) wdr <= 1'b1;
		else por <= 1'b1;
		@(posedge clk);
		wdr <= 1'b0;
		por <= 1'b0;
		mw[ISF_W_CAUSE] = wd;
	endtask : strobe_cause
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		do_reset();
		strobe_cause(1'b0);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		rchk(ISF_ADDR_FLAGS, mf);
		rchk(12'hFFC, 32'h0);
		chk(er, 1'b1);
		$display("reset and map done");
		ack_en <= 1'b1;
		apb(1'b1, ISF_ADDR_CTRL, 32'h1 | ($random(seed) & 32'h8));
		apb(1'b1, ISF_ADDR_ENABLE, $random(seed) | 32'h508);
		for (k = 0; k < 18; k++) begin
			slow <= k[0];
			pulse(eb[k]);
			mf[fb[k]] = 1'b1;
			cyc(14);
			rchk(ISF_ADDR_FLAGS, mf);
			chk(req, mreq());
			apb(1'b1, ISF_ADDR_FLAGS, fb[k] == 11 ? 32'h0 : (32'h1 << fb[k]) | 32'h800);
			cyc(6);
			chk(req, mreq());
		end
		$display("event sources done");
		ack_en <= 1'b0;
		apb(1'b1, ISF_ADDR_KEYEN, 32'h1);
		apb(1'b1, ISF_ADDR_ENABLE, 32'h1FFFF);
		for (k = 0; k < 7; k++) begin
			apb(1'b1, ISF_ADDR_CTRL, pc[k]);
			pins[pp[k]] <= 1'b0;
			cyc(12);
			if (pf[k] >= 0) mf[pf[k]] = 1'b1;
			rchk(ISF_ADDR_FLAGS, mf);
			chk(req, mreq());
			pins[pp[k]] <= 1'b1;
			cyc(12);
			apb(1'b1, ISF_ADDR_FLAGS, 32'hFFFFFFFF);
		end
		bo <= 1'b1;
		mf[22] = 1'b1;
		cyc(12);
		chk(req, mreq());
		apb(1'b1, ISF_ADDR_CTRL, 32'h9);
		bo <= 1'b0;
		cyc(6);
		chk(req, mreq());
		$display("pin sources done");
		ack_en <= 1'b1;
		apb(1'b1, ISF_ADDR_CTRL, 32'h3);
		apb(1'b1, ISF_ADDR_FLAGS, 32'hFFFFFFFF);
		pins[0] <= 1'b0;
		cyc(30);
		rchk(ISF_ADDR_FLAGS, mf);
		apb(1'b1, ISF_ADDR_CTRL, 32'h1);
		mf[0] = 1'b1;
		cyc(30);
		rchk(ISF_ADDR_FLAGS, mf);
		chk(req, mreq());
		pins[0] <= 1'b1;
		mf[0] = 1'b0;
		cyc(12);
		rchk(ISF_ADDR_FLAGS, mf);
		$display("external service done");
		apb(1'b1, ISF_ADDR_WATCHDOG_CONTROL, 32'hFB);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		apb(1'b1, ISF_ADDR_TA, ISF_TA_KEY1);
		apb(1'b1, ISF_ADDR_TA, ISF_TA_KEY2);
		apb(1'b1, ISF_ADDR_WATCHDOG_CONTROL, 32'hB2);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		apb(1'b1, ISF_ADDR_ENABLE, 32'h1FFFB);
		pulse(1);
		mw[ISF_W_IRQF] = 1'b1;
		cyc(12);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		chk(req, mreq());
		apb(1'b1, ISF_ADDR_ENABLE, 32'h1FFFF);
		cyc(6);
		chk(req, mreq());
		rchk(ISF_ADDR_REQ, mreq());
		apb(1'b1, ISF_ADDR_TA, ISF_TA_KEY1);
		apb(1'b1, ISF_ADDR_TA, ISF_TA_KEY2);
		apb(1'b1, ISF_ADDR_WATCHDOG_CONTROL, 32'hB2);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		do_reset();
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		strobe_cause(1'b1);
		do_reset();
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		strobe_cause(1'b0);
		rchk(ISF_ADDR_WATCHDOG_CONTROL, mw);
		$display("watchdog control done");
		finish_test();
	end
	// a hang stops the run well past the expected length
	initial begin
		#100000;
		err_total++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule : test_interrupt_source_flags
`default_nettype wire
